// ### ict_consts.vh
/*
 * Cycle-budget constants for the instruction cycle timing sequencer:
 * base clocks, reads and writes per operation class, and operation codes.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef ICT_CONSTS_VH
`define ICT_CONSTS_VH

// clock period in ns, for reference by derived counts
`define ICT_CLK_PERIOD_NS 8

// operation codes
`define ICT_OP_W 5
`define ICT_OP_EXT_ADD_RR_BW 5'h00
`define ICT_OP_EXT_ADD_RR_L 5'h01
`define ICT_OP_EXT_SUB_RR_BW 5'h02
`define ICT_OP_EXT_SUB_RR_L 5'h03
`define ICT_OP_DEC_ADD_RR 5'h04
`define ICT_OP_DEC_SUB_RR 5'h05
`define ICT_OP_MEM_CMP_BW 5'h06
`define ICT_OP_EXT_ADD_MM 5'h07
`define ICT_OP_EXT_SUB_MM 5'h08
`define ICT_OP_DEC_ADD_MM 5'h09
`define ICT_OP_DEC_SUB_MM 5'h0A
`define ICT_OP_CTL_TO_CR 5'h0B
`define ICT_OP_CTL_FROM_CR 5'h0C
`define ICT_OP_PLM_ST_W 5'h0D
`define ICT_OP_PLM_LD_W 5'h0E
`define ICT_OP_PLM_ST_L 5'h0F
`define ICT_OP_PLM_LD_L 5'h10
`define ICT_OP_STATUS_TO_MEM 5'h11
`define ICT_OP_EXC_ADDR_ERR 5'h12
`define ICT_OP_EXC_BUS_ERR 5'h13
`define ICT_OP_EXC_INTERRUPT 5'h14
`define ICT_OP_EXC_BREAKPOINT 5'h15

// clocks / reads / writes
`define ICT_CLK_RR_SHORT 8'h04
`define ICT_CLK_RR_LONG 8'h06
`define ICT_CLK_MEM_CMP 8'h0C
`define ICT_CLK_EXT_MM 8'h12
`define ICT_CLK_TO_CR 8'h0A
`define ICT_CLK_FROM_CR 8'h0C
`define ICT_CLK_PLM_W 8'h10
`define ICT_CLK_PLM_L 8'h18
`define ICT_CLK_STATUS_MEM 8'h08
`define ICT_CLK_BUS_ERR 8'h7E
`define ICT_CLK_INTERRUPT 8'h2E
`define ICT_CLK_BREAKPOINT 8'h2D
`define ICT_CLK_RESET 8'h28
`define ICT_RD_RESET 6'h06
`define ICT_RD_BUS_ERR 6'h04
`define ICT_WR_BUS_ERR 6'h1A
`define ICT_RD_EXC 6'h05
`define ICT_WR_EXC 6'h04
// responder completes an acknowledge cycle within this many clocks
`define ICT_ACK_CLKS 8'h04

`endif

// ### ict_bus_pacer.v
/*
 * Bus cycle pacer: runs a budget of clocks, issuing its reads and writes on back-to-back clocks from the start.
 * Assumes a single clock; start is a one-cycle pulse while idle.
 */
`timescale 1ns/100ps
`include "ict_consts.vh"

module ict_bus_pacer (
    // clock and reset
    input wire clock,
    input wire rst,
    input wire clk_en,
    // budget
    input wire start,
    input wire [7:0] clocks,
    input wire [5:0] reads,
    input wire [5:0] writes,
    // status and bus strobes
    output reg busy,
    output reg done,
    output reg rd_strobe,
    output reg wr_strobe
);

    reg [7:0] left;
    reg [5:0] rd_left;
    reg [5:0] wr_left;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            done <= 1'b0;
            rd_strobe <= 1'b0;
            wr_strobe <= 1'b0;
            left <= 8'h00;
            rd_left <= 6'h00;
            wr_left <= 6'h00;
        end else if (clk_en) begin
            done <= 1'b0;
            rd_strobe <= 1'b0;
            wr_strobe <= 1'b0;
            if (start && !busy) begin
                busy <= 1'b1;
                left <= clocks;
                rd_left <= reads;
                wr_left <= writes;
            end else if (busy) begin
                // writes first, reads last: the final read is the next fetch
                if (wr_left != 6'h00 && left > {2'h0, rd_left} + {2'h0, wr_left}) begin
                    wr_strobe <= 1'b1;
                    wr_left <= wr_left - 6'h01;
                end else if (rd_left != 6'h00 && left > {2'h0, rd_left} - 8'h01) begin
                    rd_strobe <= 1'b1;
                    rd_left <= rd_left - 6'h01;
                end else if (wr_left != 6'h00) begin
                    wr_strobe <= 1'b1;
                    wr_left <= wr_left - 6'h01;
                end
                left <= left - 8'h01;
                if (left == 8'h01) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

endmodule // ict_bus_pacer

// ### ict_sequencer.v
/*
 * Instruction cycle timing sequencer: turns an operation code plus the
 * effective-address cost into a fixed clock, read and write budget.
 * Assumes issue is a level from same-clock logic; reset_pin and halt_pin
 * are pins and pass a three-stage synchroniser.
 */
// Behaviour
// - each arithmetic count already covers operand fetch, operation, store and next fetch, nothing extra.
// - register forms of extended add/subtract take 4 clocks 1 read (byte/word) or 6 (long); decimal takes 6.
// - memory compare takes 12 clocks 3 reads; extended memory forms take 18 clocks 3 reads 1 write.
// - additive operations add the effective-address clocks, reads and writes to the base.
// - to a control register 10 clocks 2 reads; from a control register 12 clocks 2 reads.
// - peripheral lane move word 16 clocks (2 writes or 4 reads), long 24 clocks (4 writes or 6 reads).
// - status to memory uses non-fetching address time plus 8 clocks, 1 read, 1 write.
// - index register width has no effect on execution time.
// - address and bus errors take 126 clocks, 4 reads, 26 writes including stacking and vector fetch.
// - interrupt takes 46 clocks and breakpoint 45, assuming acknowledge ends within four clocks.
// - after reset and halt both read negated, 40 clocks with 6 reads and no writes precede execution.
`timescale 1ns/100ps
`include "ict_consts.vh"

module ict_sequencer (
    // clock and reset
    input wire clock,
    input wire rst,
    input wire clk_en,
    // processor control pins
    input wire reset_pin_n,
    input wire halt_pin_n,
    // operation request
    input wire issue,
    input wire [4:0] opcode,
    input wire [7:0] ea_clocks,
    input wire [5:0] ea_reads,
    input wire [5:0] ea_writes,
    input wire index_long,
    // status
    output wire ready,
    output reg running,
    output reg op_done,
    output reg [7:0] budget_clocks,
    output reg [5:0] budget_reads,
    output reg [5:0] budget_writes,
    // bus strobes
    output wire bus_read,
    output wire bus_write
);

    localparam ST_HELD = 2'h0;
    localparam ST_START = 2'h1;
    localparam ST_IDLE = 2'h2;
    localparam ST_EXEC = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: change counts when stages two and three agree
    reg [2:0] rst_sync;
    reg [2:0] halt_sync;
    reg pins_negated;
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            rst_sync <= 3'h0;
            halt_sync <= 3'h0;
            pins_negated <= 1'b0;
        end else if (clk_en) begin
            rst_sync <= {rst_sync[1:0], reset_pin_n};
            halt_sync <= {halt_sync[1:0], halt_pin_n};
            if (rst_sync[1] == rst_sync[2] && halt_sync[1] == halt_sync[2])
                pins_negated <= rst_sync[2] & halt_sync[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // budget lookup
    function [19:0] base_cost;
        input [4:0] op;
        begin
            case (op)
                `ICT_OP_EXT_ADD_RR_BW, `ICT_OP_EXT_SUB_RR_BW:
                    base_cost = {`ICT_CLK_RR_SHORT, 6'h01, 6'h00};
                `ICT_OP_EXT_ADD_RR_L, `ICT_OP_EXT_SUB_RR_L, `ICT_OP_DEC_ADD_RR, `ICT_OP_DEC_SUB_RR:
                    base_cost = {`ICT_CLK_RR_LONG, 6'h01, 6'h00};
                `ICT_OP_MEM_CMP_BW:
                    base_cost = {`ICT_CLK_MEM_CMP, 6'h03, 6'h00};
                `ICT_OP_EXT_ADD_MM, `ICT_OP_EXT_SUB_MM, `ICT_OP_DEC_ADD_MM, `ICT_OP_DEC_SUB_MM:
                    base_cost = {`ICT_CLK_EXT_MM, 6'h03, 6'h01};
                `ICT_OP_CTL_TO_CR:
                    base_cost = {`ICT_CLK_TO_CR, 6'h02, 6'h00};
                `ICT_OP_CTL_FROM_CR:
                    base_cost = {`ICT_CLK_FROM_CR, 6'h02, 6'h00};
                `ICT_OP_PLM_ST_W:
                    base_cost = {`ICT_CLK_PLM_W, 6'h02, 6'h02};
                `ICT_OP_PLM_LD_W:
                    base_cost = {`ICT_CLK_PLM_W, 6'h04, 6'h00};
                `ICT_OP_PLM_ST_L:
                    base_cost = {`ICT_CLK_PLM_L, 6'h02, 6'h04};
                `ICT_OP_PLM_LD_L:
                    base_cost = {`ICT_CLK_PLM_L, 6'h06, 6'h00};
                `ICT_OP_STATUS_TO_MEM:
                    base_cost = {`ICT_CLK_STATUS_MEM, 6'h01, 6'h01};
                `ICT_OP_EXC_ADDR_ERR, `ICT_OP_EXC_BUS_ERR:
                    base_cost = {`ICT_CLK_BUS_ERR, `ICT_RD_BUS_ERR, `ICT_WR_BUS_ERR};
                `ICT_OP_EXC_INTERRUPT:
                    base_cost = {`ICT_CLK_INTERRUPT, `ICT_RD_EXC, `ICT_WR_EXC};
                `ICT_OP_EXC_BREAKPOINT:
                    base_cost = {`ICT_CLK_BREAKPOINT, `ICT_RD_EXC, `ICT_WR_EXC};
                default:
                    base_cost = {`ICT_CLK_RR_SHORT, 6'h01, 6'h00};
            endcase
        end
    endfunction

    // only status-to-memory takes the address cost; other codes here are fixed
    function is_additive;
        input [4:0] op;
        begin
            is_additive = (op == `ICT_OP_STATUS_TO_MEM);
        end
    endfunction

    wire [19:0] cost = base_cost(opcode);
    wire add_ea = is_additive(opcode);
    // index_long deliberately unused in the sum
    wire index_ignored = index_long & 1'b0;
    wire [7:0] next_clocks = cost[19:12] + (add_ea ? ea_clocks : 8'h00) + {7'h00, index_ignored};
    wire [5:0] next_reads = cost[11:6] + (add_ea ? ea_reads : 6'h00);
    wire [5:0] next_writes = cost[5:0] + (add_ea ? ea_writes : 6'h00);

    ////////////////////////////////////////////////////////////////////////
    // control
    reg [1:0] state;
    reg pace_start;
    wire pace_busy;
    wire pace_done;

    assign ready = (state == ST_IDLE) && !pace_busy;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= ST_HELD;
            running <= 1'b0;
            op_done <= 1'b0;
            pace_start <= 1'b0;
            budget_clocks <= 8'h00;
            budget_reads <= 6'h00;
            budget_writes <= 6'h00;
        end else if (clk_en) begin
            pace_start <= 1'b0;
            op_done <= 1'b0;
            if (!pins_negated && state != ST_HELD) begin
                state <= ST_HELD;
                running <= 1'b0;
            end else begin
                case (state)
                    ST_HELD: begin
                        // a budget cut short by the pins must drain first, or start-up runs short
                        if (pins_negated && !pace_busy) begin
                            budget_clocks <= `ICT_CLK_RESET;
                            budget_reads <= `ICT_RD_RESET;
                            budget_writes <= 6'h00;
                            pace_start <= 1'b1;
                            state <= ST_START;
                        end
                    end
                    ST_START: begin
                        if (pace_done) begin
                            running <= 1'b1;
                            state <= ST_IDLE;
                        end
                    end
                    ST_IDLE: begin
                        if (issue && ready) begin
                            budget_clocks <= next_clocks;
                            budget_reads <= next_reads;
                            budget_writes <= next_writes;
                            pace_start <= 1'b1;
                            state <= ST_EXEC;
                        end
                    end
                    ST_EXEC: begin
                        if (pace_done) begin
                            op_done <= 1'b1;
                            state <= ST_IDLE;
                        end
                    end
                    default: state <= ST_HELD;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // paced bus cycles inside the fixed budget
    ict_bus_pacer u_pacer (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .start(pace_start),
        .clocks(budget_clocks),
        .reads(budget_reads),
        .writes(budget_writes),
        .busy(pace_busy),
        .done(pace_done),
        .rd_strobe(bus_read),
        .wr_strobe(bus_write)
    );

endmodule // ict_sequencer

// ### ict_seq_chk.sv
/* checker for ict_sequencer budgets and op timing
   assumes one clock domain; bound to every ict_sequencer */
`timescale 1ns/100ps
`include "ict_consts.vh"
module ict_seq_chk (
    // request side
    input wire clock,
    input wire rst,
    input wire clk_en,
    input wire issue,
    input wire [4:0] opcode,
    input wire [7:0] ea_clocks,
    // status side
    input wire ready,
    input wire op_done,
    input wire [7:0] budget_clocks,
    input wire [5:0] budget_reads,
    input wire [5:0] budget_writes,
    input wire bus_read,
    input wire bus_write
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    wire take = issue && ready && clk_en;
    wire [19:0] bud = {budget_clocks, budget_reads, budget_writes};
    reg [9:0] cyc;
    reg [5:0] nrd;
    reg [5:0] nwr;
    ////////////////////////////////////////
    // restart on each take so start-up pulses stay out
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            cyc <= 10'h000;
            nrd <= 6'h00;
            nwr <= 6'h00;
        end else if (clk_en) begin
            cyc <= take ? 10'h000 : cyc + 10'h001;
            nrd <= take ? 6'h00 : nrd + {5'h00, bus_read};
            nwr <= take ? 6'h00 : nwr + {5'h00, bus_write};
        end
    end
    property p_rr; take && opcode == `ICT_OP_EXT_SUB_RR_BW |=> bud == {8'h04, 6'h01, 6'h00}; endproperty
    a_rr: assert property (p_rr) else $error("rr budget");
    property p_cmp; take && opcode == `ICT_OP_MEM_CMP_BW |=> bud == {8'h0C, 6'h03, 6'h00}; endproperty
    a_cmp: assert property (p_cmp) else $error("cmp budget");
    property p_ctl; take && opcode == `ICT_OP_CTL_FROM_CR |=> bud == {8'h0C, 6'h02, 6'h00}; endproperty
    a_ctl: assert property (p_ctl) else $error("ctl budget");
    property p_stat; take && opcode == `ICT_OP_STATUS_TO_MEM |=> budget_clocks == 8'h08 + $past(ea_clocks); endproperty
    a_stat: assert property (p_stat) else $error("status budget");
    property p_err; take && opcode == `ICT_OP_EXC_ADDR_ERR |=> bud == {8'h7E, 6'h04, 6'h1A}; endproperty
    a_err: assert property (p_err) else $error("error budget");
    property p_irq; take && opcode == `ICT_OP_EXC_INTERRUPT |=> bud == {8'h2E, 6'h05, 6'h04}; endproperty
    a_irq: assert property (p_irq) else $error("irq budget");
    property p_time; op_done |-> cyc == {2'h0, budget_clocks} + 10'h002; endproperty
    a_time: assert property (p_time) else $error("done late or early");
    property p_cnt; op_done |-> nrd == budget_reads && nwr == budget_writes; endproperty
    a_cnt: assert property (p_cnt) else $error("bus cycle count");
    property p_pulse; op_done |=> !op_done; endproperty
    a_pulse: assert property (p_pulse) else $error("done too long");
    c_take: cover property (take);
    c_done: cover property (op_done);
    c_b2b: cover property (op_done && take);
endmodule // ict_seq_chk

bind ict_sequencer ict_seq_chk chk (.clock(clock), .rst(rst), .clk_en(clk_en), .issue(issue), .opcode(opcode),
    .ea_clocks(ea_clocks), .ready(ready), .op_done(op_done), .budget_clocks(budget_clocks),
    .budget_reads(budget_reads), .budget_writes(budget_writes), .bus_read(bus_read), .bus_write(bus_write));

// ### ict_bus_model.sv
/* memory and peripheral model: totals the read and write cycles
   assumes one strobe pulse per bus cycle */
`timescale 1ns/100ps
module ict_bus_model (
    // clock and strobes
    input wire clock,
    input wire rst,
    input wire bus_read,
    input wire bus_write,
    // totals
    output int reads,
    output int writes
);
    ////////////////////////////////////////
    // every cycle ends at once, well inside the four-clock acknowledge allowance
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            reads <= 0;
            writes <= 0;
        end else begin
            reads <= reads + bus_read;
            writes <= writes + bus_write;
        end
    end
endmodule // ict_bus_model

// ### testbench.sv
/* bench for ict_sequencer: start-up, every opcode, random ops, pin hold
   assumes ict_bus_model and the bound checker are compiled too */
`timescale 1ns/100ps
`include "ict_consts.vh"
module testbench;
    reg clock = 1'b0;
    reg rst = 1'b1;
    reg clk_en = 1'b1;
    reg reset_pin_n = 1'b0;
    reg halt_pin_n = 1'b0;
    reg issue = 1'b0;
    reg index_long = 1'b0;
    reg [4:0] opcode = 5'h00;
    reg [7:0] ea_clocks = 8'h00;
    reg [5:0] ea_reads = 6'h00;
    reg [5:0] ea_writes = 6'h00;
    wire ready, running, op_done, bus_read, bus_write;
    wire [7:0] budget_clocks;
    wire [5:0] budget_reads, budget_writes;
    int reads, writes, i;
    int fails = 0;
    int checked = 0;
    int seed = 61597;
    always #4 clock = ~clock;
    ict_sequencer uut (.clock(clock), .rst(rst), .clk_en(clk_en), .reset_pin_n(reset_pin_n),
        .halt_pin_n(halt_pin_n), .issue(issue), .opcode(opcode), .ea_clocks(ea_clocks), .ea_reads(ea_reads),
        .ea_writes(ea_writes), .index_long(index_long), .ready(ready), .running(running), .op_done(op_done),
        .budget_clocks(budget_clocks), .budget_reads(budget_reads), .budget_writes(budget_writes),
        .bus_read(bus_read), .bus_write(bus_write));
    ict_bus_model bus (.clock(clock), .rst(rst), .bus_read(bus_read), .bus_write(bus_write),
        .reads(reads), .writes(writes));
    ////////////////////////////////////////
    function automatic [19:0] want_of(input [4:0] op, input [7:0] ec, input [5:0] er, input [5:0] ew);
        case (op)
            `ICT_OP_EXT_ADD_RR_L, `ICT_OP_EXT_SUB_RR_L, `ICT_OP_DEC_ADD_RR, `ICT_OP_DEC_SUB_RR:
                want_of = {8'h06, 6'h01, 6'h00};
            `ICT_OP_MEM_CMP_BW: want_of = {8'h0C, 6'h03, 6'h00};
            `ICT_OP_EXT_ADD_MM, `ICT_OP_EXT_SUB_MM, `ICT_OP_DEC_ADD_MM, `ICT_OP_DEC_SUB_MM:
                want_of = {8'h12, 6'h03, 6'h01};
            `ICT_OP_CTL_TO_CR: want_of = {8'h0A, 6'h02, 6'h00};
            `ICT_OP_CTL_FROM_CR: want_of = {8'h0C, 6'h02, 6'h00};
            `ICT_OP_PLM_ST_W: want_of = {8'h10, 6'h02, 6'h02};
            `ICT_OP_PLM_LD_W: want_of = {8'h10, 6'h04, 6'h00};
            `ICT_OP_PLM_ST_L: want_of = {8'h18, 6'h02, 6'h04};
            `ICT_OP_PLM_LD_L: want_of = {8'h18, 6'h06, 6'h00};
            `ICT_OP_STATUS_TO_MEM: want_of = {8'h08 + ec, 6'h01 + er, 6'h01 + ew};
            `ICT_OP_EXC_ADDR_ERR, `ICT_OP_EXC_BUS_ERR: want_of = {8'h7E, 6'h04, 6'h1A};
            `ICT_OP_EXC_INTERRUPT: want_of = {8'h2E, 6'h05, 6'h04};
            `ICT_OP_EXC_BREAKPOINT: want_of = {8'h2D, 6'h05, 6'h04};
            default: want_of = {8'h04, 6'h01, 6'h00};
        endcase
    endfunction
    task automatic chk(input string what, input [19:0] seen, input [19:0] want);
        checked++;
        if (seen !== want) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, want, seen);
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic start_up;
        int n, r0, w0;
        n = 0;
        r0 = reads;
        w0 = writes;
        @(negedge clock);
        reset_pin_n = 1'b1;
        halt_pin_n = 1'b1;
        while (running !== 1'b1 && n < 200) begin
            @(negedge clock);
            n++;
        end
        chk("startup span", {19'h0, n >= 40 && n <= 48}, 20'h1);
        chk("startup bus", 20'((reads - r0) * 64 + writes - w0), 20'h180);
        if (n >= 200) wrap_up;
    endtask
    // issue stays high while busy, with junk codes the design must refuse
    task automatic run_op(input [4:0] op);
        int n, r0, w0;
        reg [19:0] want;
        n = 0;
        @(negedge clock);
        while (ready !== 1'b1 && n < 400) begin
            @(negedge clock);
            n++;
        end
        if (n >= 400) begin
            fails++;
            wrap_up;
        end
        opcode = op;
        ea_reads = 6'($random(seed) & 7);
        ea_writes = 6'($random(seed) & 7);
        // each added bus cycle brings at least four clocks, so the budget can hold it
        ea_clocks = 8'(4 * (ea_reads + ea_writes) + ($random(seed) & 3));
        index_long = 1'($random(seed));
        issue = 1'b1;
        want = want_of(op, ea_clocks, ea_reads, ea_writes);
        r0 = reads;
        w0 = writes;
        @(posedge clock);
        #1;
        n = 0;
        chk("budget", {budget_clocks, budget_reads, budget_writes}, want);
        @(negedge clock);
        opcode = 5'($random(seed));
        while (op_done !== 1'b1 && n < 400) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk("done cycle", n[19:0], {12'h0, want[19:12]} + 20'h2);
        chk("reads", 20'(reads - r0), {14'h0, want[11:6]});
        chk("writes", 20'(writes - w0), {14'h0, want[5:0]});
        chk("budget held", {budget_clocks, budget_reads, budget_writes}, want);
        if (n >= 400) wrap_up;
    endtask
    initial begin
        repeat (10) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        start_up;
        for (i = 0; i < 22; i++)
            run_op(5'(i));
        for (i = 0; i < 40; i++)
            run_op(5'({$random(seed)} % 22));
        @(negedge clock);
        issue = 1'b0;
        halt_pin_n = 1'b0;
        repeat (8) @(negedge clock);
        chk("held", {19'h0, running}, 20'h0);
        // enable low freezes the synchroniser, so released pins must not restart
        clk_en = 1'b0;
        halt_pin_n = 1'b1;
        repeat (20) @(negedge clock);
        chk("frozen", {19'h0, running}, 20'h0);
        clk_en = 1'b1;
        start_up;
        run_op(`ICT_OP_EXC_BUS_ERR);
        @(negedge clock);
        issue = 1'b0;
        wrap_up;
    end
endmodule // testbench
